/* bench/plc_acc.sv */
// Behavioural headset accessory at the far end of the power line.
`timescale 1ns/1ps
module plc_acc (
    input  wire logic clk,      // Clock.
    input  wire logic line,     // Resolved line level.
    input  wire logic dev_oe_n, // Device drive enable.
    output logic      acc_oe,   // High while driving.
    output logic      acc_out   // Driven level.
);
    int          cyc = 0;
    int          bt;
    int          nbits;
    logic [17:0] got;

    initial begin
        acc_oe = 1'b0;
        acc_out = 1'b0;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // Decodes a device frame: bit time, the two bytes with parity, length.
    initial forever begin : dec
        int t0;
        int t1;
        @(posedge clk iff !dev_oe_n);
        t0 = cyc;
        @(posedge clk iff !line);
        t1 = cyc;
        bt = (t1 - t0 + 4) / 8;
        for (int i = 0; i < 18; i++) begin
            while (cyc < t1 + bt + i * bt + bt / 2) @(posedge clk);
            got[17 - i] = line;
        end
        @(posedge clk iff dev_oe_n);
        nbits = (cyc - t0 + bt / 2) / bt;
    end

    // Sends id and two bytes with odd parity and 16 trailing lows.
    task automatic send(input logic [23:0] d, input int t, input logic bad);
        logic [49:0] f;
        f = {6'h3f, 1'b0, d[23:16], ~^d[23:16] ^ bad, d[15:8], ~^d[15:8],
             d[7:0], ~^d[7:0], 16'h0000};
        for (int i = 49; i >= 0; i--) begin
            @(posedge clk);
            acc_oe <= 1'b1;
            acc_out <= f[i];
            repeat (t - 1) @(posedge clk);
        end
        @(posedge clk);
        acc_oe <= 1'b0;
    endtask : send

    // Pulls the line low over the device for n cycles.
    task automatic jam(input int n);
        @(posedge clk);
        acc_oe <= 1'b1;
        acc_out <= 1'b0;
        repeat (n) @(posedge clk);
        acc_oe <= 1'b0;
    endtask : jam
endmodule : plc_acc

/* bench/plc_link_bench.sv */
// Self-checking bench for the power line link engine.
`timescale 1ns/1ps
module plc_link_bench;
    import plc_pkg::*;
    localparam int U0 = 8;
    localparam int U1 = 10;
    logic        clk, rst, ce, reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, ctl, s;
    logic        line_out, line_oe_n, sink_current_select, int_n, acc_oe, acc_out;
    logic [31:0] v;
    logic [7:0]  rq[$];
    logic [7:0]  rv[10] = '{0, 0, 0, 8'h04, 0, 0, 0, 0, 0, 0};
    int          n_fail, tests_run, seed;
    wire         line_in = acc_oe ? acc_out : (!line_oe_n && line_out);

    plc_link #(.UNIT0(U0), .UNIT1(U1)) plc_link_i (.clk(clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out),
        .line_oe_n(line_oe_n), .sink_current_select(sink_current_select), .int_n(int_n));
    plc_acc plc_acc_i (.clk(clk), .line(line_in), .dev_oe_n(line_oe_n), .acc_oe(acc_oe),
        .acc_out(acc_out));

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("register %0h", a), {24'h0, e}, {24'h0, d});
    endtask : chk_reg
    task automatic wait_tx();
        logic [7:0] t;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 12000; i++) begin
            rd(ADDR_STATUS, t);
            if (t[ST_TXP] === 1'b0) break;
        end
        chk("transmit end", 32'h0, {31'h0, t[ST_TXP]});
        repeat (4) @(negedge clk);
    endtask : wait_tx
    function automatic logic par(input int m, input logic [7:0] b);
        return m == 1 ? ~^b : (m == 2 ? ^b : 1'b1);
    endfunction : par
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
    initial begin
        seed = 26;
        n_fail = 0;
        tests_run = 0;
        rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        foreach (rv[i]) chk_reg(8'h15 + 8'(i), rv[i]);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(ADDR_MASK, v[7:0]);
            chk_reg(ADDR_MASK, v[7:0] & 8'h3f);
        end
        $display("test reset and mask done");
        wr(ADDR_MASK, 8'h00);
        ce = 1'b0;
        wr(ADDR_MASK, 8'h3f);
        ce = 1'b1;
        chk_reg(ADDR_MASK, 8'h00);
        wr(ADDR_TADDR, 8'hff);
        wr(ADDR_CONTROL, 8'h25);
        repeat (12 * U0) @(negedge clk);
        plc_acc_i.jam(2 * U0);
        wait_tx();
        chk_reg(ADDR_STATUS, 8'h20);
        chk("int_n masked", 32'h1, {31'h0, int_n});
        chk_reg(ADDR_IRQ, 8'h28);
        repeat (30 * U1) @(negedge clk);
        $display("test transmit error done");
        wr(ADDR_MASK, 8'h3f);
        for (int m = 0; m < 5; m++) begin
            v = $random(seed);
            ctl = {1'b0, v[16], m < 4, m[0], m[1:0], 2'b01};
            wr(ADDR_TADDR, v[7:0]);
            wr(ADDR_TBYTE, v[15:8]);
            rd(ADDR_IRQ, s);
            wr(ADDR_CONTROL, ctl);
            wait_tx();
            chk("bit time", m[0] ? U1 : U0, plc_acc_i.bt);
            chk("frame", {14'h0, v[7:0], par(m % 4, v[7:0]), v[15:8],
                par(m % 4, v[15:8])}, {14'h0, plc_acc_i.got});
            chk("length", m < 4 ? 27 : 2027, plc_acc_i.nbits);
            chk("int_n", 32'h0, {31'h0, int_n});
            chk_reg(ADDR_CONTROL, ctl & 8'hfe);
            chk_reg(ADDR_STATUS, 8'h10);
            chk_reg(ADDR_IRQ, 8'h18);
        end
        $display("test transmit done");
        wr(ADDR_CONTROL, 8'h04);
        rd(ADDR_IRQ, s);
        for (int k = 0; k < 2; k++) begin
            v = $random(seed);
            fork
                // Short runs of ones keep a dropped frame's tail from passing as a preamble.
                plc_acc_i.send(v[23:0] & (k ? 24'h333333 : 24'hffffff), U0, k[0]);
                begin
                    repeat (12 * U0) @(negedge clk);
                    chk_reg(ADDR_STATUS, 8'h11);
                end
            join
            repeat (U0) @(negedge clk);
            if (k == 0) begin
                rq = {v[23:16], v[15:8], v[7:0]};
                chk_reg(ADDR_STATUS, 8'h12);
                chk_reg(ADDR_IRQ, 8'h03);
                chk_reg(ADDR_IDENT, rq[0]);
                chk_reg(ADDR_RX_ONE, rq[1]);
                chk_reg(ADDR_STATUS, 8'h12);
                chk_reg(ADDR_RX_TWO, rq[2]);
                chk_reg(ADDR_STATUS, 8'h10);
            end else begin
                chk_reg(ADDR_STATUS, 8'h14);
                chk_reg(ADDR_IDENT, rq[0]);
            end
        end
        $display("test receive done");
        wrap_up();
    end
endmodule : plc_link_bench

/* bench/plc_link_monitor.sv */
// Port checker for the power line link engine, bound to its top module.
`timescale 1ns/1ps
module plc_link_monitor #(
    parameter int UNIT0 = 8,
    parameter int UNIT1 = 10
) (
    input wire logic       clk,                 // Clock.
    input wire logic       rst,                 // Reset.
    input wire logic [7:0] reg_addr,            // Address.
    input wire logic       reg_wr,              // Write.
    input wire logic       reg_rd,              // Read.
    input wire logic [7:0] reg_wdata,           // Write data.
    input wire logic [7:0] reg_rdata,           // Read data.
    input wire logic       line_out,            // Line level.
    input wire logic       line_oe_n,           // Line enable.
    input wire logic       sink_current_select, // Sink select.
    input wire logic       int_n                // Interrupt.
);
    localparam int PRE0 = 8 * UNIT0;
    localparam int PRE1 = 8 * UNIT1;
    localparam int MAXF = 2027 * UNIT1;
    logic [15:0] low_cnt;
    wire         go = reg_wr && reg_addr == 8'h18 && reg_wdata[0] && line_oe_n;

    // Counts how long the line has been driven in one stretch.
    always_ff @(posedge clk) begin
        if (rst || line_oe_n) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_reset_quiet;
        disable iff (1'b0) rst |=> line_oe_n && int_n && reg_rdata == 8'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not idle after reset");
    property p_send_start;
        go |=> !line_oe_n && line_out;
    endproperty
    a_send_start: assert property (p_send_start)
        else $error("send did not start a frame");
    property p_delim0;
        go && !reg_wdata[4] |-> ##PRE0 line_out ##1 (!line_out && !line_oe_n);
    endproperty
    a_delim0: assert property (p_delim0)
        else $error("short unit preamble length wrong");
    property p_delim1;
        go && reg_wdata[4] |-> ##PRE1 line_out ##1 (!line_out && !line_oe_n);
    endproperty
    a_delim1: assert property (p_delim1)
        else $error("long unit preamble length wrong");
    property p_frame_len;
        low_cnt <= MAXF;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("line driven too long");
    property p_sink;
        reg_wr && reg_addr == 8'h18 |=> sink_current_select == $past(reg_wdata[6]);
    endproperty
    a_sink: assert property (p_sink)
        else $error("sink select does not follow control");
    property p_unmapped;
        reg_rd && reg_addr > 8'h1d |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed without a read");

    c_send: cover property (go);
    c_irq: cover property ($fell(int_n));
    c_rx: cover property (reg_rd && reg_addr == 8'h1b);
endmodule : plc_link_monitor

bind plc_link plc_link_monitor #(.UNIT0(UNIT0), .UNIT1(UNIT1)) plc_link_monitor_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_out(line_out),
    .line_oe_n(line_oe_n), .sink_current_select(sink_current_select), .int_n(int_n));

/* verilog/plc_bit_timer.sv */
// Bit time counter giving a mid-bit sample tick and an end-of-bit tick.
`timescale 1ns/1ps
module plc_bit_timer import plc_pkg::*; #(
    parameter int UNIT0 = UNIT0_CYC,
    parameter int UNIT1 = UNIT1_CYC
) (
    input  wire logic clk,      // System clock.
    input  wire logic rst,      // Synchronous reset, active high.
    input  wire logic ce,       // Clock enable.
    input  wire logic restart,  // Start a fresh bit period.
    input  wire logic unit_sel, // Selects the longer time unit.
    output logic      mid,      // Middle of the bit period.
    output logic      last      // Last cycle of the bit period.
);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } plc_tmr_t;

    plc_tmr_t         s;
    plc_tmr_t         next_s;
    logic [TMR_W-1:0] unit;

    assign unit = unit_sel ? TMR_W'(UNIT1) : TMR_W'(UNIT0);
    assign mid  = (s.cnt == (unit >> 1));
    assign last = (s.cnt == unit - TMR_W'(1));

    always_comb begin
        next_s = s;
        if (restart || last) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + TMR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

endmodule : plc_bit_timer

/* verilog/plc_link.sv */
// Power line link engine: registers, frame transmitter and frame receiver.
`timescale 1ns/1ps
module plc_link import plc_pkg::*; #(
    parameter int UNIT0 = UNIT0_CYC,
    parameter int UNIT1 = UNIT1_CYC
) (
    input  wire logic       clk,                 // System clock, 200 MHz.
    input  wire logic       rst,                 // Synchronous reset, active high.
    input  wire logic       ce,                  // Clock enable, freezes all state.
    input  wire logic [7:0] reg_addr,            // Register address.
    input  wire logic       reg_wr,              // Register write strobe.
    input  wire logic       reg_rd,              // Register read strobe.
    input  wire logic [7:0] reg_wdata,           // Register write data.
    output logic      [7:0] reg_rdata,           // Register read data.
    input  wire logic       line_in,             // Power line level seen at the pin.
    output logic            line_out,            // Level driven onto the line.
    output logic            line_oe_n,           // Low while the line is driven.
    output logic            sink_current_select, // Sink current level select.
    output logic            int_n                // Interrupt, active low.
);

    typedef struct packed {
        logic [1:0]  sync;
        logic        line_d;
        logic [5:0]  mask;
        logic        sink;
        logic        tdis;
        logic        tusel;
        logic [1:0]  par;
        logic        send;
        logic [7:0]  taddr;
        logic [7:0]  tbyte;
        logic [5:0]  stat;
        logic [5:0]  stat_d;
        logic [5:0]  irqf;
        logic [7:0]  accessory_identifier;
        logic [7:0]  rx_one;
        logic [7:0]  rx_two;
        logic [2:0]  seen;
        logic [7:0]  rdata;
        logic        int_n;
        logic        line_o;
        logic        line_oe_n;
        plc_tx_t     tx;
        logic [10:0] tx_cnt;
        logic [8:0]  tx_sh;
        logic        tx_idx;
        plc_rx_t     rx;
        logic [3:0]  rx_bit;
        logic [1:0]  rx_idx;
        logic [4:0]  rx_run;
        logic [8:0]  rx_sh;
        logic [23:0] rx_buf;
    } plc_state_t;

    plc_state_t s;
    plc_state_t next_s;

    logic       line_s;
    logic       rx_edge;
    logic       tx_start;
    logic       tx_mid;
    logic       tx_last;
    logic       rx_mid;
    logic       rx_last;
    logic [5:0] set_st;
    logic [5:0] clr_st;
    logic [5:0] irq_clr;
    logic [5:0] rise;
    logic [5:0] fall;
    logic [2:0] seen_now;
    logic       tx_drive;

    // The second synchroniser stage is the line level the logic works on.
    assign line_s  = s.sync[1];
    assign rx_edge = s.sync[1] ^ s.line_d;

    assign tx_start = reg_wr && (reg_addr == ADDR_CONTROL) && reg_wdata[CTL_SEND]
                      && (s.tx == PLC_TX_IDLE);

    assign tx_drive = (s.tx == PLC_TX_PRE) || (s.tx == PLC_TX_DELIM)
                      || (s.tx == PLC_TX_BYTE);

    plc_bit_timer #(
        .UNIT0 (UNIT0),
        .UNIT1 (UNIT1)
    ) u_tx_timer (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .restart  (tx_start),
        .unit_sel (s.tusel),
        .mid      (tx_mid),
        .last     (tx_last)
    );

    // The receive timer realigns on every line edge so sampling tracks the sender.
    plc_bit_timer #(
        .UNIT0 (UNIT0),
        .UNIT1 (UNIT1)
    ) u_rx_timer (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .restart  (rx_edge),
        .unit_sel (s.tusel),
        .mid      (rx_mid),
        .last     (rx_last)
    );

    always_comb begin
        next_s   = s;
        set_st   = '0;
        clr_st   = '0;
        irq_clr  = '0;
        seen_now = '0;
        rise     = s.stat & ~s.stat_d;
        fall     = ~s.stat & s.stat_d & BOTH_EDGE_SRC;

        next_s.sync   = {s.sync[0], line_in};
        next_s.line_d = s.sync[1];

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MASK: begin
                    next_s.mask = reg_wdata[5:0];
                end
                ADDR_CONTROL: begin
                    next_s.sink  = reg_wdata[CTL_SINK];
                    next_s.tdis  = reg_wdata[CTL_TDIS];
                    next_s.tusel = reg_wdata[CTL_TUSEL];
                    next_s.par   = reg_wdata[CTL_PAR +: 2];
                end
                ADDR_TADDR: begin
                    next_s.taddr = reg_wdata;
                end
                ADDR_TBYTE: begin
                    next_s.tbyte = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // Register reads and their side effects.
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: begin
                    next_s.rdata = {2'h0, s.stat};
                end
                ADDR_IRQ: begin
                    next_s.rdata = {2'h0, s.irqf};
                    irq_clr      = s.irqf;
                end
                ADDR_MASK: begin
                    next_s.rdata = {2'h0, s.mask};
                end
                ADDR_CONTROL: begin
                    next_s.rdata = {1'b0, s.sink, s.tdis, s.tusel, s.par, 1'b0, s.send};
                end
                ADDR_IDENT: begin
                    next_s.rdata = s.accessory_identifier;
                    seen_now[0]  = 1'b1;
                end
                ADDR_RX_ONE: begin
                    next_s.rdata = s.rx_one;
                    seen_now[1]  = 1'b1;
                end
                ADDR_RX_TWO: begin
                    next_s.rdata = s.rx_two;
                    seen_now[2]  = 1'b1;
                end
                ADDR_TADDR: begin
                    next_s.rdata = s.taddr;
                end
                ADDR_TBYTE: begin
                    next_s.rdata = s.tbyte;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        next_s.seen = s.seen | seen_now;
        if (&next_s.seen) begin
            clr_st[ST_NEW] = 1'b1;
            next_s.seen    = '0;
        end

        // Transmitter.
        if (tx_drive && tx_mid && (line_s != s.line_o)) begin
            next_s.send      = 1'b0;
            set_st[ST_TXE]   = 1'b1;
            clr_st[ST_TXP]   = 1'b1;
            next_s.line_oe_n = 1'b1;
            next_s.line_o    = 1'b0;
            next_s.tx        = PLC_TX_IDLE;
        end else begin
            unique case (s.tx)
                PLC_TX_IDLE: begin
                    if (tx_start) begin
                        next_s.send      = 1'b1;
                        clr_st[ST_TXE]   = 1'b1;
                        clr_st[ST_TXOK]  = 1'b1;
                        set_st[ST_TXP]   = 1'b1;
                        next_s.tx        = PLC_TX_PRE;
                        next_s.tx_cnt    = '0;
                        next_s.line_o    = 1'b1;
                        next_s.line_oe_n = 1'b0;
                    end
                end
                PLC_TX_PRE: begin
                    if (tx_last) begin
                        if (s.tx_cnt == PRE_BITS - 11'h1) begin
                            next_s.tx     = PLC_TX_DELIM;
                            next_s.line_o = 1'b0;
                        end else begin
                            next_s.tx_cnt = s.tx_cnt + 11'h1;
                        end
                    end
                end
                PLC_TX_DELIM: begin
                    if (tx_last) begin
                        next_s.tx     = PLC_TX_BYTE;
                        next_s.tx_sh  = {s.taddr, plc_parity(s.par, s.taddr)};
                        next_s.line_o = s.taddr[7];
                        next_s.tx_idx = 1'b0;
                        next_s.tx_cnt = '0;
                    end
                end
                PLC_TX_BYTE: begin
                    if (tx_last) begin
                        if (s.tx_cnt != BYTE_BITS - 11'h1) begin
                            next_s.tx_sh  = {s.tx_sh[7:0], 1'b0};
                            next_s.line_o = s.tx_sh[7];
                            next_s.tx_cnt = s.tx_cnt + 11'h1;
                        end else if (!s.tx_idx) begin
                            next_s.tx_sh  = {s.tbyte, plc_parity(s.par, s.tbyte)};
                            next_s.line_o = s.tbyte[7];
                            next_s.tx_idx = 1'b1;
                            next_s.tx_cnt = '0;
                        end else begin
                            next_s.send     = 1'b0;
                            set_st[ST_TXOK] = 1'b1;
                            next_s.tx_cnt   = '0;
                            next_s.line_o   = 1'b0;
                            if (s.tdis) begin
                                clr_st[ST_TXP]   = 1'b1;
                                next_s.line_oe_n = 1'b1;
                                next_s.tx        = PLC_TX_IDLE;
                            end else begin
                                next_s.tx = PLC_TX_POST;
                            end
                        end
                    end
                end
                PLC_TX_POST: begin
                    if (tx_last) begin
                        if (s.tx_cnt == TX_POST_BITS - 11'h1) begin
                            clr_st[ST_TXP]   = 1'b1;
                            next_s.line_oe_n = 1'b1;
                            next_s.tx        = PLC_TX_IDLE;
                        end else begin
                            next_s.tx_cnt = s.tx_cnt + 11'h1;
                        end
                    end
                end
            endcase
        end

        // Receiver; it stands idle while this end owns the line.
        if (s.tx != PLC_TX_IDLE) begin
            next_s.rx      = PLC_RX_IDLE;
            next_s.rx_run  = '0;
            clr_st[ST_DET] = 1'b1;
        end else if (rx_mid) begin
            unique case (s.rx)
                PLC_RX_IDLE: begin
                    if (!line_s) begin
                        next_s.rx_run = '0;
                    end else if (s.rx_run == DET_BITS - 5'h1) begin
                        next_s.rx      = PLC_RX_PRE;
                        set_st[ST_DET] = 1'b1;
                        clr_st[ST_RXE] = 1'b1;
                    end else begin
                        next_s.rx_run = s.rx_run + 5'h1;
                    end
                end
                PLC_RX_PRE: begin
                    if (!line_s) begin
                        next_s.rx     = PLC_RX_DATA;
                        next_s.rx_bit = '0;
                        next_s.rx_idx = '0;
                    end
                end
                PLC_RX_DATA: begin
                    next_s.rx_sh = {s.rx_sh[7:0], line_s};
                    if (s.rx_bit != 4'(BYTE_BITS - 11'h1)) begin
                        next_s.rx_bit = s.rx_bit + 4'h1;
                    end else if (plc_parity_on(s.par)
                                 && (plc_parity(s.par, s.rx_sh[7:0]) != line_s)) begin
                        set_st[ST_RXE] = 1'b1;
                        clr_st[ST_DET] = 1'b1;
                        next_s.rx      = PLC_RX_IDLE;
                        next_s.rx_run  = '0;
                    end else begin
                        next_s.rx_buf = {s.rx_buf[15:0], s.rx_sh[7:0]};
                        next_s.rx_bit = '0;
                        if (s.rx_idx == RX_BYTES - 2'h1) begin
                            next_s.rx      = PLC_RX_POST;
                            next_s.rx_run  = '0;
                            clr_st[ST_DET] = 1'b1;
                        end else begin
                            next_s.rx_idx = s.rx_idx + 2'h1;
                        end
                    end
                end
                PLC_RX_POST: begin
                    if (line_s) begin
                        set_st[ST_RXE] = 1'b1;
                        next_s.rx      = PLC_RX_IDLE;
                        next_s.rx_run  = '0;
                    end else if (s.rx_run == RX_POST_BITS - 5'h1) begin
                        next_s.accessory_identifier  = s.rx_buf[23:16];
                        next_s.rx_one  = s.rx_buf[15:8];
                        next_s.rx_two  = s.rx_buf[7:0];
                        set_st[ST_NEW] = 1'b1;
                        next_s.seen    = '0;
                        next_s.rx      = PLC_RX_IDLE;
                        next_s.rx_run  = '0;
                    end else begin
                        next_s.rx_run = s.rx_run + 5'h1;
                    end
                end
            endcase
        end

        // A flag set in the same cycle as its clear stays set.
        next_s.stat   = (s.stat & ~clr_st) | set_st;
        next_s.stat_d = s.stat;
        next_s.irqf   = (s.irqf & ~irq_clr) | rise | fall;
        next_s.int_n  = ~|(next_s.irqf & next_s.mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s           <= '0;
            s.par       <= CTL_RESET[CTL_PAR +: 2];
            s.tx        <= PLC_TX_IDLE;
            s.rx        <= PLC_RX_IDLE;
            s.int_n     <= 1'b1;
            s.line_oe_n <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign reg_rdata           = s.rdata;
    assign line_out            = s.line_o;
    assign line_oe_n           = s.line_oe_n;
    assign sink_current_select = s.sink;
    assign int_n               = s.int_n;

endmodule : plc_link

/* verilog/plc_pkg.sv */
// Constants, state types and parity helpers for the power line link engine.
package plc_pkg;

    localparam logic [7:0] ADDR_STATUS  = 8'h15;
    localparam logic [7:0] ADDR_IRQ     = 8'h16;
    localparam logic [7:0] ADDR_MASK    = 8'h17;
    localparam logic [7:0] ADDR_CONTROL = 8'h18;
    localparam logic [7:0] ADDR_IDENT   = 8'h19;
    localparam logic [7:0] ADDR_RX_ONE  = 8'h1a;
    localparam logic [7:0] ADDR_RX_TWO  = 8'h1b;
    localparam logic [7:0] ADDR_TADDR   = 8'h1c;
    localparam logic [7:0] ADDR_TBYTE   = 8'h1d;

    localparam int CTL_SEND  = 0;
    localparam int CTL_PAR   = 2;
    localparam int CTL_TUSEL = 4;
    localparam int CTL_TDIS  = 5;
    localparam int CTL_SINK  = 6;
    localparam logic [7:0] CTL_RESET = 8'h04;

    localparam int ST_DET  = 0;
    localparam int ST_NEW  = 1;
    localparam int ST_RXE  = 2;
    localparam int ST_TXP  = 3;
    localparam int ST_TXOK = 4;
    localparam int ST_TXE  = 5;
    localparam logic [5:0] BOTH_EDGE_SRC = 6'h09;

    localparam logic [1:0] PAR_ODD  = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    localparam int CLK_PERIOD_NS = 5;
    localparam int UNIT0_NS      = 24000;
    localparam int UNIT1_NS      = 30000;
    localparam int UNIT0_CYC     = UNIT0_NS / CLK_PERIOD_NS;
    localparam int UNIT1_CYC     = UNIT1_NS / CLK_PERIOD_NS;
    localparam int TMR_W         = 13;

    localparam logic [10:0] PRE_BITS     = 11'h008;
    localparam logic [10:0] BYTE_BITS    = 11'h009;
    localparam logic [10:0] TX_POST_BITS = 11'h7d0;
    localparam logic [4:0]  DET_BITS     = 5'h04;
    localparam logic [4:0]  RX_POST_BITS = 5'h10;
    localparam logic [1:0]  RX_BYTES     = 2'h3;

    typedef enum logic [2:0] {
        PLC_TX_IDLE, PLC_TX_PRE, PLC_TX_DELIM, PLC_TX_BYTE, PLC_TX_POST
    } plc_tx_t;

    typedef enum logic [1:0] {
        PLC_RX_IDLE, PLC_RX_PRE, PLC_RX_DATA, PLC_RX_POST
    } plc_rx_t;

    // Parity bit that goes with a byte; a high bit when parity is off.
    function automatic logic plc_parity(input logic [1:0] mode, input logic [7:0] d);
        if (mode == PAR_ODD) begin
            return ~^d;
        end else if (mode == PAR_EVEN) begin
            return ^d;
        end
        return 1'b1;
    endfunction : plc_parity

    function automatic logic plc_parity_on(input logic [1:0] mode);
        return (mode == PAR_ODD) || (mode == PAR_EVEN);
    endfunction : plc_parity_on

endpackage : plc_pkg
